// ### logic/macfg_top.sv
// Metering accumulator routing and capture-port configuration block
`timescale 1ns/100ps
module macfg_top
  import macfg_pkg::*;
#(
  parameter int PERIOD_UNIT_CYC = CLK_HZ / LINE_HZ,
  parameter int ACC_W           = 32
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       cap_clk,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [macfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [macfg_pkg::DATA_W-1:0] reg_wdata,
  output logic      [macfg_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       select_pin,
  input  wire logic                       power_mode_change,
  input  wire logic                       line_cycle_done,
  input  wire logic [2:0]                 zero_cross_in,
  input  wire logic                       sample_strobe,
  input  wire logic [15:0]                va,
  input  wire logic [15:0]                vb,
  input  wire logic [15:0]                vc,
  input  wire logic [15:0]                ia,
  input  wire logic [15:0]                ib,
  input  wire logic [15:0]                ic,
  input  wire logic [15:0]                ia_q,
  input  wire logic [15:0]                ib_q,
  input  wire logic [15:0]                ic_q,
  input  wire logic [15:0]                va_rms,
  input  wire logic [15:0]                vb_rms,
  input  wire logic [15:0]                vc_rms,
  input  wire logic [15:0]                ia_rms,
  input  wire logic [15:0]                ib_rms,
  input  wire logic [15:0]                ic_rms,
  input  wire logic                       capture_start,
  output logic                            capture_serial_data,
  output logic                            select_or_capture_select_pin,
  output logic                            spi_active,
  output logic                            port_locked,
  output logic                            external_reference_en,
  output logic [2:0]                      overcurrent_threshold,
  output logic [31:0]                     low_power_period_cyc,
  output logic [2:0]                      zero_cross_phase_select,
  output logic [2:0]                      zero_cross_count_inc,
  output logic                            line_cycle_active_en,
  output logic                            line_cycle_reactive_en,
  output logic                            line_cycle_apparent_en
);
  import macfg_pkg::*;

  logic [7:0] lcm_r, cap_r, lpo_r, cf2_r, am_r;
  logic [1:0] sel_sync_r;
  logic       sel_prev_r;
  logic [1:0] toggle_cnt_r;
  macfg_port_e port_r;
  logic       lock_r;
  logic signed [ACC_W-1:0] acc_r [0:8];
  logic signed [ACC_W-1:0] prod [0:8];
  logic signed [15:0] vb_eff;
  logic       wire_zero_b;
  logic [3:0] acc_idx;
  logic       acc_hit;

  function automatic logic signed [ACC_W-1:0] mul16(
    input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return ACC_W'(p);
  endfunction

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcm_r <= RST_LINE_CYCLE_MODE;
      cap_r <= RST_CAPTURE_CFG;
      lpo_r <= RST_LOW_POWER_OC;
      cf2_r <= RST_SECOND_CONFIG;
      am_r  <= RST_ACCUM_MODE;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_LINE_CYCLE_MODE:      lcm_r <= reg_wdata & MASK_LINE_CYCLE_MODE;
        ADDR_CAPTURE_PORT_CONFIG:  cap_r <= reg_wdata & MASK_CAPTURE_CFG;
        ADDR_LOW_POWER_OC_LEVEL:   lpo_r <= reg_wdata & MASK_LOW_POWER_OC;
        ADDR_SECOND_CONFIGURATION: cf2_r <= reg_wdata & MASK_SECOND_CONFIG;
        ADDR_ACCUM_MODE:           am_r  <= reg_wdata & MASK_ACCUM_MODE;
        default: ;
      endcase
    end
  end

  assign acc_hit = (reg_addr >= ADDR_PHASE_A_ACTIVE_ENERGY) &&
                   (reg_addr <= ADDR_ENERGY_LAST) && !reg_addr[0];
  assign acc_idx = 4'((reg_addr - ADDR_PHASE_A_ACTIVE_ENERGY) >> 1);

  // Read data; accumulators return their top byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_LINE_CYCLE_MODE:      reg_rdata <= lcm_r;
        ADDR_CAPTURE_PORT_CONFIG:  reg_rdata <= cap_r;
        ADDR_LOW_POWER_OC_LEVEL:   reg_rdata <= lpo_r;
        ADDR_SECOND_CONFIGURATION: reg_rdata <= {cf2_r[7:2], lock_r, cf2_r[0]};
        ADDR_ACCUM_MODE:           reg_rdata <= am_r;
        default: begin
          if (acc_hit && acc_idx < 4'(POWER_WORDS))
            reg_rdata <= acc_r[acc_idx][ACC_W-1 -: DATA_W];
          else
            reg_rdata <= '0;
        end
      endcase
    end
  end

  // Phase B voltage derivation by wiring type
  always_comb begin
    wire_zero_b = 1'b0;
    case (am_r[AM_WIRE_HI:AM_WIRE_LO])
      WIRE_DELTA3:   begin vb_eff = vb; wire_zero_b = 1'b1; end
      WIRE_FOUR_TWO: vb_eff = 16'(-va - vc);
      WIRE_DELTA4:   vb_eff = 16'(-va);
      default:       vb_eff = vb;
    endcase
  end

  // Order: A/B/C active, A/B/C reactive, A/B/C apparent
  always_comb begin
    prod[0] = mul16(va, ia);
    prod[1] = wire_zero_b ? '0 : mul16(vb_eff, ib);
    prod[2] = mul16(vc, ic);
    prod[3] = mul16(va, ia_q);
    prod[4] = wire_zero_b ? '0 : mul16(vb_eff, ib_q);
    prod[5] = mul16(vc, ic_q);
    prod[6] = mul16(va_rms, ia_rms);
    prod[7] = wire_zero_b ? '0 : mul16(vb_rms, ib_rms);
    prod[8] = mul16(vc_rms, ic_rms);
  end

  // Accumulators; line-cycle groups restart at each line-cycle boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < POWER_WORDS; i++) acc_r[i] <= '0;
    end else begin
      for (int i = 0; i < POWER_WORDS; i++) begin
        if (reg_rd && lcm_r[LCM_CLR_READ] && acc_hit && acc_idx == 4'(i))
          acc_r[i] <= '0;
        else if (line_cycle_done && lcm_r[i / 3])
          acc_r[i] <= prod[i];
        else if (sample_strobe)
          acc_r[i] <= acc_r[i] + prod[i];
      end
    end
  end

  // Configuration outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_cycle_active_en    <= 1'b0;
      line_cycle_reactive_en  <= 1'b0;
      line_cycle_apparent_en  <= 1'b0;
      zero_cross_phase_select <= '0;
      zero_cross_count_inc    <= '0;
      overcurrent_threshold   <= '0;
      low_power_period_cyc    <= '0;
      external_reference_en   <= 1'b0;
    end else begin
      line_cycle_active_en    <= lcm_r[LCM_ACTIVE];
      line_cycle_reactive_en  <= lcm_r[LCM_REACTIVE];
      line_cycle_apparent_en  <= lcm_r[LCM_APPARENT];
      zero_cross_phase_select <= lcm_r[LCM_ZX_HI:LCM_ZX_LO];
      zero_cross_count_inc    <= zero_cross_in & lcm_r[LCM_ZX_HI:LCM_ZX_LO];
      overcurrent_threshold   <= lpo_r[LPO_TH_HI:LPO_TH_LO];
      low_power_period_cyc    <= 32'((32'(lpo_r[LPO_LN_HI:LPO_LN_LO]) + 32'd1)
                                 * 32'(PERIOD_UNIT_CYC));
      external_reference_en   <= cf2_r[CF2_EXTREF];
    end
  end

  // Select pin synchroniser and previous-level register for edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_sync_r <= 2'b11;
      sel_prev_r <= 1'b1;
    end else begin
      sel_sync_r <= {sel_sync_r[0], select_pin};
      sel_prev_r <= sel_sync_r[1];
    end
  end

  // Port choice; power mode changes do not touch it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_r       <= MACFG_PORT_I2C;
      lock_r       <= 1'b0;
      toggle_cnt_r <= '0;
    end else begin
      if (reg_wr && reg_addr == ADDR_SECOND_CONFIGURATION &&
          (port_r == MACFG_PORT_SPI || reg_wdata[CF2_LOCK]))
        lock_r <= 1'b1;
      if (!lock_r && port_r == MACFG_PORT_I2C &&
          sel_prev_r != sel_sync_r[1]) begin
        if (toggle_cnt_r == 2'(SELECT_TOGGLES - 1))
          port_r <= MACFG_PORT_SPI;
        toggle_cnt_r <= 2'(toggle_cnt_r + 2'd1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_active  <= 1'b0;
      port_locked <= 1'b0;
    end else begin
      spi_active  <= (port_r == MACFG_PORT_SPI);
      port_locked <= lock_r;
    end
  end

  // Capture snapshot: handshake into link domain
  logic [WORD_BITS-1:0] snap_r [0:POWER_WORDS-1];
  logic [5:0] cap_cfg_r;
  logic       req_r;
  logic       ack_l_r;
  logic [1:0] ack_sync_r;
  logic [1:0] xfer;

  assign xfer = (cap_r[CAP_XFER_HI:CAP_XFER_LO] == XFER_RESERVED) ?
                XFER_DEFAULT : cap_r[CAP_XFER_HI:CAP_XFER_LO];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r      <= 1'b0;
      ack_sync_r <= '0;
      cap_cfg_r  <= '0;
      for (int i = 0; i < POWER_WORDS; i++) snap_r[i] <= '0;
    end else begin
      ack_sync_r <= {ack_sync_r[0], ack_l_r};
      // Config follows the register while the link is idle, frozen in a frame
      if (req_r == ack_sync_r[1]) begin
        cap_cfg_r <= {cap_r[CAP_POL], xfer, cap_r[CAP_GAP:CAP_CLK]};
        if (capture_start) begin
          req_r <= !req_r;
          // Power transfer: apparent, active, then reactive words; otherwise accumulators active, reactive, apparent
          for (int i = 0; i < POWER_WORDS; i++)
            snap_r[i] <= (xfer == XFER_POWER) ?
                         32'(prod[(i + 6) % POWER_WORDS]) :
                         32'(acc_r[i]);
        end
      end
    end
  end

  // Link domain
  logic [2:0] req_sync_l_r;
  logic [1:0] pol_sync_l_r;
  macfg_cap_e st_l_r;
  logic [3:0] word_l_r;
  logic [4:0] bit_l_r;
  logic [2:0] gap_l_r;
  logic       div_l_r;

  always_ff @(posedge cap_clk or posedge rst) begin
    if (rst) begin
      req_sync_l_r                 <= '0;
      pol_sync_l_r                 <= '0;
      ack_l_r                      <= 1'b0;
      st_l_r                       <= MACFG_IDLE;
      word_l_r                     <= '0;
      bit_l_r                      <= '0;
      gap_l_r                      <= '0;
      div_l_r                      <= 1'b0;
      capture_serial_data          <= 1'b0;
      select_or_capture_select_pin <= 1'b1;
    end else begin
      req_sync_l_r <= {req_sync_l_r[1:0], req_r};
      pol_sync_l_r <= {pol_sync_l_r[0], cap_cfg_r[CAP_POL]};
      div_l_r <= cap_cfg_r[CAP_CLK] ? !div_l_r : 1'b0;
      case (st_l_r)
        MACFG_IDLE: begin
          select_or_capture_select_pin <= !pol_sync_l_r[1];
          if (req_sync_l_r[2] != ack_l_r) begin
            st_l_r   <= MACFG_SEND;
            word_l_r <= '0;
            bit_l_r  <= 5'(WORD_BITS - 1);
          end
        end
        MACFG_SEND: if (!div_l_r) begin
          select_or_capture_select_pin <= cap_cfg_r[CAP_POL];
          capture_serial_data <= snap_r[word_l_r][bit_l_r];
          if (bit_l_r == '0) begin
            bit_l_r <= 5'(WORD_BITS - 1);
            if (word_l_r == 4'(POWER_WORDS - 1)) st_l_r <= MACFG_DONE;
            else begin
              word_l_r <= 4'(word_l_r + 4'd1);
              if (cap_cfg_r[CAP_GAP]) st_l_r <= MACFG_GAP;
            end
          end else begin
            bit_l_r <= 5'(bit_l_r - 5'd1);
            if (cap_cfg_r[CAP_SIZE] && bit_l_r[2:0] == 3'd0 &&
                cap_cfg_r[CAP_GAP]) st_l_r <= MACFG_GAP;
          end
          gap_l_r <= 3'(GAP_CYCLES - 1);
        end
        MACFG_GAP: if (!div_l_r) begin
          select_or_capture_select_pin <= !cap_cfg_r[CAP_POL];
          if (gap_l_r == '0) st_l_r <= MACFG_SEND;
          else gap_l_r <= 3'(gap_l_r - 3'd1);
        end
        MACFG_DONE: begin
          select_or_capture_select_pin <= !cap_cfg_r[CAP_POL];
          ack_l_r <= req_sync_l_r[2];
          st_l_r  <= MACFG_IDLE;
        end
        default: st_l_r <= MACFG_IDLE;
      endcase
    end
  end
endmodule

// ### logic/macfg_pkg.sv
// Package with register map, field layout, reset values and timing of the metering configuration block
package macfg_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] ADDR_LINE_CYCLE_MODE      = 16'hE702;
  localparam logic [15:0] ADDR_CAPTURE_PORT_CONFIG  = 16'hE706;
  localparam logic [15:0] ADDR_LOW_POWER_OC_LEVEL   = 16'hEC00;
  localparam logic [15:0] ADDR_SECOND_CONFIGURATION = 16'hEC01;
  localparam logic [15:0] ADDR_ACCUM_MODE           = 16'hE701;
  localparam logic [15:0] ADDR_PHASE_A_ACTIVE_ENERGY = 16'hE400;
  localparam logic [15:0] ADDR_ENERGY_LAST          = 16'hE40E;

  localparam logic [7:0] RST_LINE_CYCLE_MODE  = 8'h78;
  localparam logic [7:0] RST_CAPTURE_CFG      = 8'h00;
  localparam logic [7:0] RST_LOW_POWER_OC     = 8'h07;
  localparam logic [7:0] RST_SECOND_CONFIG    = 8'h00;
  localparam logic [7:0] RST_ACCUM_MODE       = 8'h00;

  localparam logic [7:0] MASK_LINE_CYCLE_MODE = 8'h7F;
  localparam logic [7:0] MASK_CAPTURE_CFG     = 8'h3F;
  localparam logic [7:0] MASK_LOW_POWER_OC    = 8'hFF;
  localparam logic [7:0] MASK_SECOND_CONFIG   = 8'h03;
  localparam logic [7:0] MASK_ACCUM_MODE      = 8'h30;

  localparam int LCM_ACTIVE   = 0;
  localparam int LCM_REACTIVE = 1;
  localparam int LCM_APPARENT = 2;
  localparam int LCM_ZX_LO    = 3;
  localparam int LCM_ZX_HI    = 5;
  localparam int LCM_CLR_READ = 6;
  localparam int CAP_CLK      = 0;
  localparam int CAP_SIZE     = 1;
  localparam int CAP_GAP      = 2;
  localparam int CAP_XFER_LO  = 3;
  localparam int CAP_XFER_HI  = 4;
  localparam int CAP_POL      = 5;
  localparam int LPO_TH_LO    = 0;
  localparam int LPO_TH_HI    = 2;
  localparam int LPO_LN_LO    = 3;
  localparam int LPO_LN_HI    = 7;
  localparam int CF2_EXTREF   = 0;
  localparam int CF2_LOCK     = 1;
  localparam int AM_WIRE_LO   = 4;
  localparam int AM_WIRE_HI   = 5;

  localparam logic [1:0] WIRE_FOUR_THREE = 2'h0;
  localparam logic [1:0] WIRE_DELTA3     = 2'h1;
  localparam logic [1:0] WIRE_FOUR_TWO   = 2'h2;
  localparam logic [1:0] WIRE_DELTA4     = 2'h3;
  localparam logic [1:0] XFER_POWER      = 2'h2;
  localparam logic [1:0] XFER_RESERVED   = 2'h3;
  localparam logic [1:0] XFER_DEFAULT    = 2'h0;

  localparam int SELECT_TOGGLES  = 3;
  localparam int GAP_CYCLES      = 7;
  localparam int WORD_BITS       = 32;
  localparam int PACK_BYTE_BITS  = 8;
  localparam int POWER_WORDS     = 9;
  localparam int THRESH_DIV_LOG2 = 3;
  localparam int LINE_HZ         = 50;
  localparam int CLK_HZ          = 100_000_000;
  localparam int LINK_DIV_FAST   = 1;
  localparam int LINK_DIV_SLOW   = 2;
  localparam int PERIOD_MAX_CYC  = 64_000_000;

  typedef enum logic [3:0] {
    MACFG_IDLE = 4'b0001,
    MACFG_SEND = 4'b0010,
    MACFG_GAP  = 4'b0100,
    MACFG_DONE = 4'b1000
  } macfg_cap_e;

  typedef enum logic [1:0] {
    MACFG_PORT_I2C = 2'b01,
    MACFG_PORT_SPI = 2'b10
  } macfg_port_e;
endpackage

// ### verif/macfg_top_monitor.sv
// Checker of the register-driven outputs of the metering configuration block
`timescale 1ns/100ps
module macfg_chk
  import macfg_pkg::*;
#(
  parameter int PERIOD_UNIT_CYC = 10
) (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [macfg_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [macfg_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic [macfg_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic                          power_mode_change,
  input wire logic                          spi_active,
  input wire logic                          port_locked,
  input wire logic                          external_reference_en,
  input wire logic [2:0]                    overcurrent_threshold,
  input wire logic [31:0]                   low_power_period_cyc,
  input wire logic [2:0]                    zero_cross_phase_select,
  input wire logic                          line_cycle_active_en,
  input wire logic                          line_cycle_reactive_en,
  input wire logic                          line_cycle_apparent_en
);
  import macfg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wl;
  logic wc;
  logic wp;
  assign wl = reg_wr && reg_addr == ADDR_LINE_CYCLE_MODE;
  assign wc = reg_wr && reg_addr == ADDR_SECOND_CONFIGURATION;
  assign wp = reg_wr && reg_addr == ADDR_LOW_POWER_OC_LEVEL;
  property p_lc_act;
    wl |-> ##2 line_cycle_active_en == $past(reg_wdata[0], 2);
  endproperty
  property p_lc_var;
    wl |-> ##2 line_cycle_reactive_en == $past(reg_wdata[1], 2);
  endproperty
  property p_lc_va;
    wl |-> ##2 line_cycle_apparent_en == $past(reg_wdata[2], 2);
  endproperty
  property p_zx;
    wl |-> ##2 zero_cross_phase_select == $past(reg_wdata[5:3], 2);
  endproperty
  property p_oc;
    wp |-> ##2 overcurrent_threshold == $past(reg_wdata[2:0], 2);
  endproperty
  property p_period;
    wp |-> ##2 low_power_period_cyc ==
      ({27'h0, $past(reg_wdata[7:3], 2)} + 32'h1) * PERIOD_UNIT_CYC;
  endproperty
  property p_extref;
    wc |-> ##2 external_reference_en == $past(reg_wdata[0], 2);
  endproperty
  property p_spi_lock;
    wc && spi_active |-> ##2 port_locked;
  endproperty
  property p_lock_hold;
    port_locked |=> port_locked && $stable(spi_active);
  endproperty
  property p_rsv;
    reg_rd && reg_addr == ADDR_SECOND_CONFIGURATION |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_lc_act: assert property (p_lc_act) else $error("active mode bit");
  a_lc_var: assert property (p_lc_var) else $error("reactive mode bit");
  a_lc_va: assert property (p_lc_va) else $error("apparent mode bit");
  a_zx: assert property (p_zx) else $error("zero cross select");
  a_oc: assert property (p_oc) else $error("overcurrent level");
  a_period: assert property (p_period) else $error("low power period");
  a_extref: assert property (p_extref) else $error("reference select");
  a_spi_lock: assert property (p_spi_lock) else $error("spi not locked");
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  c_lcm: cover property (wl);
  c_spi_lock: cover property (wc && spi_active);
  c_pm: cover property (port_locked && power_mode_change);
endmodule
bind macfg_top macfg_chk #(.PERIOD_UNIT_CYC(PERIOD_UNIT_CYC)) u_chk (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .power_mode_change(power_mode_change), .spi_active(spi_active),
  .port_locked(port_locked), .external_reference_en(external_reference_en),
  .overcurrent_threshold(overcurrent_threshold),
  .low_power_period_cyc(low_power_period_cyc),
  .zero_cross_phase_select(zero_cross_phase_select),
  .line_cycle_active_en(line_cycle_active_en),
  .line_cycle_reactive_en(line_cycle_reactive_en),
  .line_cycle_apparent_en(line_cycle_apparent_en));

// ### verif/macfg_host.sv
// Host controller model driving the register port and the select pin
`timescale 1ns/100ps
module macfg_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [15:0]     reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  output logic            select_pin
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    select_pin = 1'b1;
  end
  // Released lines show the inverse of their last value
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // Drops clear-on-read whenever line-cycle accumulation is enabled
  task automatic set_lcm(input logic [7:0] d);
    if (d[2:0] != 3'h0) begin
      d[6] = 1'b0;
    end
    wr(16'hE702, d);
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      #1;
      select_pin = ~select_pin;
    end
    repeat (6) @(posedge clk);
  endtask
endmodule

// ### verif/macfg_top_test.sv
// Self-checking testbench of the metering configuration block
`timescale 1ns/100ps
module macfg_top_test;
  import macfg_pkg::*;
  logic clk = 1'b0;
  logic cap_clk = 1'b0;
  logic rst = 1'b1;
  logic rw, rr, sel, pmc, lcd, strb, cst, sd, pin, spi, lck, ext;
  logic lca, lcr, lcv;
  logic [15:0] ra, smp;
  logic [7:0] wd, rdat, d;
  logic [2:0] zxi, oct, zxs, zxc, seen;
  logic [31:0] per;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int ones;
  logic [15:0] ad [4] = '{16'hE702, 16'hE706, 16'hEC00, 16'hEC01};
  logic [7:0] rv [4] = '{8'h78, 8'h00, 8'h07, 8'h00};
  logic [7:0] fv [4] = '{8'h7F, 8'h3F, 8'hFF, 8'h03};
  always #5 clk = ~clk;
  always #32 cap_clk = ~cap_clk;
  macfg_host HOST (.clk(clk), .reg_wr(rw), .reg_rd(rr), .reg_addr(ra),
    .reg_wdata(wd), .reg_rdata(rdat), .select_pin(sel));
  macfg_top #(.PERIOD_UNIT_CYC(10)) DUT (.clk(clk), .rst(rst),
    .cap_clk(cap_clk), .reg_wr(rw), .reg_rd(rr), .reg_addr(ra),
    .reg_wdata(wd), .reg_rdata(rdat), .select_pin(sel),
    .power_mode_change(pmc), .line_cycle_done(lcd), .zero_cross_in(zxi),
    .sample_strobe(strb), .va(smp), .vb(smp), .vc(smp), .ia(smp),
    .ib(smp), .ic(smp), .ia_q(smp), .ib_q(smp), .ic_q(smp),
    .va_rms(smp), .vb_rms(smp), .vc_rms(smp), .ia_rms(smp),
    .ib_rms(smp), .ic_rms(smp), .capture_start(cst),
    .capture_serial_data(sd), .select_or_capture_select_pin(pin),
    .spi_active(spi), .port_locked(lck), .external_reference_en(ext),
    .overcurrent_threshold(oct), .low_power_period_cyc(per),
    .zero_cross_phase_select(zxs), .zero_cross_count_inc(zxc),
    .line_cycle_active_en(lca), .line_cycle_reactive_en(lcr),
    .line_cycle_apparent_en(lcv));
  task automatic end_sim;
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    HOST.rd(a, d);
    chk("rdata", {24'h0, d}, {24'h0, e});
  endtask
  task automatic do_rst;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    repeat (2) @(posedge cap_clk);
    @(posedge clk);
    #1;
    rst = 1'b0;
  endtask
  task automatic pulse_strobe;
    @(posedge clk);
    #1;
    strb = 1'b1;
    @(posedge clk);
    #1;
    strb = 1'b0;
  endtask
  // Runs one capture frame and counts link edges with the select active
  task automatic cap_run(input logic [7:0] cfg, input int lo, input int hi);
    HOST.wr(16'hE706, cfg);
    repeat (40) @(posedge clk);
    chk("sel_idle", {31'h0, pin}, {31'h0, ~cfg[5]});
    #1;
    cst = 1'b1;
    @(posedge clk);
    #1;
    cst = 1'b0;
    n = 0;
    while (pin !== cfg[5] && n < 3000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    ones = 0;
    while (pin === cfg[5] && n < 2000) begin
      @(posedge cap_clk);
      #1;
      n++;
      ones += int'(sd === 1'b1);
    end
    chk("frame_len", {31'h0, n >= lo && n <= hi}, 32'h1);
    chk("ones", ones, cfg[0] ? 32'd18 : 32'd9);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    {pmc, lcd, strb, cst} = 4'h0;
    zxi = 3'h0;
    smp = 16'h4000;
    do_rst();
    for (int i = 0; i < 4; i++) begin
      rchk(ad[i], rv[i]);
      HOST.wr(ad[i], 8'hFF);
      rchk(ad[i], fv[i]);
    end
    rchk(16'hE703, 8'h00);
    chk("ext", {31'h0, ext}, 32'h1);
    HOST.wr(16'hEC00, 8'h2A);
    @(posedge clk);
    #1;
    chk("thresh", {29'h0, oct}, 32'h2);
    chk("period", per, 32'd60);
    for (int i = 0; i < 3; i++) begin
      HOST.set_lcm(8'h01 << i);
      @(posedge clk);
      #1;
      chk("lc_modes", {29'h0, lcv, lcr, lca}, 32'h1 << i);
    end
    HOST.wr(16'hE702, 8'h10);
    #1;
    zxi = 3'h7;
    seen = 3'h0;
    repeat (4) begin
      @(posedge clk);
      #1;
      zxi = 3'h0;
      seen = seen | zxc;
    end
    chk("zx_inc", {29'h0, seen}, 32'h2);
    HOST.toggle(3);
    chk("spi_i2c_locked", {30'h0, spi, lck}, 32'h1);
    // Return the pin to its idle high level before the next reset
    HOST.toggle(1);
    do_rst();
    HOST.toggle(3);
    chk("spi", {31'h0, spi}, 32'h1);
    HOST.wr(16'hEC01, 8'h00);
    @(posedge clk);
    #1;
    chk("lock", {31'h0, lck}, 32'h1);
    #1;
    pmc = 1'b1;
    @(posedge clk);
    #1;
    pmc = 1'b0;
    HOST.toggle(3);
    chk("spi_lock", {30'h0, spi, lck}, 32'h3);
    pulse_strobe();
    rchk(16'hE400, 8'h10);
    rchk(16'hE400, 8'h00);
    HOST.wr(16'hE702, 8'h38);
    pulse_strobe();
    rchk(16'hE400, 8'h10);
    rchk(16'hE400, 8'h10);
    cap_run(8'h10, 287, 289);
    cap_run(8'h31, 575, 577);
    end_sim();
  end
endmodule
